// *** scsel_ctrl.sv ***
// System clock source select and external oscillator control with APB registers.
//
// Notes on behaviour
// RULE1 - System clock external only when source bit set.
// RULE2 - External oscillator still clocks peripherals when unselected.
// RULE3 - Only an enabled, settled source may be selected.
// RULE4 - One internal control write enables and selects it.
// RULE5 - Hardware sets crystal valid once oscillator settled.
// RULE6 - Software waits 1 ms before checking valid.
// RULE7 - Valid flag only in crystal modes, else zero.
// RULE8 - Mode 00x turns external oscillator off.
// RULE9 - Mode 01x takes CMOS clock from pin one.
// RULE10 - Mode 10x is RC/C with divide by two.
// RULE11 - Mode 110 is crystal without division.
// RULE12 - Mode 111 is crystal divided by two.
// RULE13 - Control bit 3 reads zero, ignores writes.
// RULE14 - Software matches frequency field to crystal range.
// RULE15 - RC code chosen by frequency band.
// RULE16 - RC code 100 for 200 to 400 kHz.
// RULE17 - Internal divider codes give /8, /4, /2, /1.
// RULE18 - Source switch never produces a shortened clock phase.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "scsel_regs.svh"

module scsel_ctrl #(
  parameter int SETTLE_EDGES = `SCSEL_SETTLE_EDGES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_pin_one,
  output logic sysclk_en,
  output logic ext_periph_en,
  output logic sysclk_is_ext,
  output logic ext_osc_on,
  output scsel_pkg::scsel_xmode_t ext_osc_mode,
  output scsel_pkg::scsel_xfreq_t ext_freq_range,
  output logic int_osc_on,
  output logic irq
);
  import scsel_pkg::*;

  if (SETTLE_EDGES < 1 || SETTLE_EDGES > 65535) begin : g_bad_settle
    $error("SETTLE_EDGES must lie in 1..65535");
  end

  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_EDGES - 1);

  // --------------------------------------------------------------------------
  // Mode decoding.
  // --------------------------------------------------------------------------
  function automatic logic mode_off(input scsel_xmode_t m);
    return m[2:1] == 2'b00;
  endfunction : mode_off

  function automatic logic mode_crystal(input scsel_xmode_t m);
    return m[2:1] == 2'b11;
  endfunction : mode_crystal

  function automatic logic mode_halved(input scsel_xmode_t m);
    return (m[2:1] == 2'b10) || (m == 3'h7);
  endfunction : mode_halved

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------
  logic pin_s1_r, pin_s2_r, pin_d_r;
  logic srcsel_r, sys_ext_r, target_r;
  logic iosc_en_r;
  logic [1:0] internal_clock_divider_field_r;
  scsel_xmode_t xmode_r;
  scsel_xfreq_t xfreq_r;
  logic valid_r;
  logic [15:0] settle_cnt_r;
  logic [`SCSEL_EV_NUM-1:0] ist_r, imask_r, ev;
  logic [31:0] prdata_r;
  scsel_state_t state_r;

  logic pin_edge, int_tick, ext_tick, ext_ready, cur_tick, old_alive, drained;
  logic wr, rd_setup, wr_src, wr_iosc, wr_xosc, req, req_ext, req_ok, mapped;
  logic [3:0] int_ratio, ext_ratio;

  // --------------------------------------------------------------------------
  // Pin synchroniser; only the second stage feeds the edge detector.
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      pin_s1_r <= osc_pin_one;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign pin_edge = pin_s2_r & ~pin_d_r; // [RULE9]

  // --------------------------------------------------------------------------
  // Oscillator dividers.
  // --------------------------------------------------------------------------
  // The internal oscillator is modelled by pclk itself; the code picks 8, 4, 2 or 1.
  assign int_ratio = 4'h8 >> internal_clock_divider_field_r; // [RULE17]
  // RC/C and crystal-with-halving modes pass every second pin edge.
  assign ext_ratio = mode_halved(xmode_r) ? 4'h2 : 4'h1; // [RULE10] [RULE12]

  scsel_tick_div #(
    .W(4)
  ) u_int_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(iosc_en_r),
    .src_tick(1'b1),
    .ratio(int_ratio),
    .tick(int_tick)
  );

  scsel_tick_div #(
    .W(4)
  ) u_ext_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(ext_osc_on),
    .src_tick(pin_edge),
    .ratio(ext_ratio),
    .tick(ext_tick)
  );

  // A crystal counts as ready only once settled; CMOS and RC/C need no start-up.
  assign ext_ready = !mode_off(xmode_r) && (!mode_crystal(xmode_r) || valid_r); // [RULE3]

  // --------------------------------------------------------------------------
  // Crystal settle detection.
  // --------------------------------------------------------------------------
  // Settling is judged by a run of pin edges; a write that leaves crystal mode clears the
  // flag on the same edge, so the flag never outlives the mode or shows up in a readback.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_r <= 16'h0000;
      valid_r <= 1'b0;
    end else if (!mode_crystal(xmode_r) || (wr_xosc && pwdata[6:5] != 2'b11)) begin
      settle_cnt_r <= 16'h0000; // [RULE7]
      valid_r <= 1'b0; // [RULE7]
    end else if (pin_edge && !valid_r) begin
      settle_cnt_r <= settle_cnt_r + 16'h0001;
      valid_r <= (settle_cnt_r == SETTLE_LAST); // [RULE5]
    end
  end

  // --------------------------------------------------------------------------
  // APB decode.
  // --------------------------------------------------------------------------
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_src = wr && (paddr == `SCSEL_OFF_SRCSEL);
  assign wr_iosc = wr && (paddr == `SCSEL_OFF_IOSC);
  assign wr_xosc = wr && (paddr == `SCSEL_OFF_XOSC);

  always_comb begin
    if (paddr == `SCSEL_OFF_SRCSEL) begin
      mapped = 1'b1;
    end else if (paddr == `SCSEL_OFF_IOSC) begin
      mapped = 1'b1;
    end else if (paddr == `SCSEL_OFF_XOSC) begin
      mapped = 1'b1;
    end else if (paddr == `SCSEL_OFF_ISTAT) begin
      mapped = 1'b1;
    end else if (paddr == `SCSEL_OFF_IMASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // --------------------------------------------------------------------------
  // Source requests: from the select register, or from one internal control write.
  // --------------------------------------------------------------------------
  assign req = wr_src || (wr_iosc && pwdata[`SCSEL_IOSC_EN_BIT] && pwdata[`SCSEL_IOSC_SEL_BIT]);
  assign req_ext = wr_src ? pwdata[`SCSEL_SRC_BIT] : 1'b0;
  // The internal oscillator starts at once, so the enabling write counts as ready.
  assign req_ok = (state_r == ST_RUN) && (req_ext ? ext_ready
                  : (iosc_en_r || wr_iosc)); // [RULE3] [RULE4]

  // --------------------------------------------------------------------------
  // Registers written by software.
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srcsel_r <= 1'b0;
    end else if (req && req_ok) begin
      srcsel_r <= req_ext; // [RULE1] [RULE4]
    end
  end

  // The internal oscillator cannot be stopped while it drives the system clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iosc_en_r <= `SCSEL_IOSC_EN_RESET;
      internal_clock_divider_field_r <= `SCSEL_INTERNAL_CLOCK_DIVIDER_FIELD_RESET;
    end else if (wr_iosc) begin
      iosc_en_r <= pwdata[`SCSEL_IOSC_EN_BIT] | ~sys_ext_r; // [RULE4]
      internal_clock_divider_field_r <= pwdata[1:0]; // [RULE17]
    end
  end

  // Bit 3 has no storage, so writes to it vanish.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xmode_r <= scsel_xmode_t'(`SCSEL_XOSC_RESET >> 4);
      xfreq_r <= 3'h0;
    end else if (wr_xosc) begin
      xmode_r <= pwdata[6:4];
      xfreq_r <= pwdata[2:0]; // [RULE13]
    end
  end

  // --------------------------------------------------------------------------
  // Switch sequencer: finish the old source's period before taking the new one.
  // --------------------------------------------------------------------------
  assign cur_tick = sys_ext_r ? ext_tick : int_tick;
  assign old_alive = sys_ext_r ? ext_ready : iosc_en_r;
  assign drained = cur_tick | ~old_alive;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      sys_ext_r <= 1'b0;
      target_r <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (req && req_ok && (req_ext != sys_ext_r)) begin
            target_r <= req_ext;
            state_r <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (drained) begin
            sys_ext_r <= target_r; // [RULE18]
            state_r <= ST_WAIT_NEW;
          end
        end
        ST_WAIT_NEW: begin
          if (cur_tick) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // Every system clock tick is a whole tick of exactly one source.
  assign sysclk_en = cur_tick; // [RULE1] [RULE18]
  assign ext_periph_en = ext_tick; // [RULE2]
  assign sysclk_is_ext = sys_ext_r;
  assign ext_osc_on = !mode_off(xmode_r); // [RULE8] [RULE11]
  assign ext_osc_mode = xmode_r;
  assign ext_freq_range = xfreq_r;
  assign int_osc_on = iosc_en_r;

  // --------------------------------------------------------------------------
  // Interrupts: sticky events, write one to clear, a new event beats the clear.
  // --------------------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[`SCSEL_EV_VALID] = mode_crystal(xmode_r) && pin_edge && !valid_r
                          && (settle_cnt_r == SETTLE_LAST);
    ev[`SCSEL_EV_SWITCHED] = (state_r == ST_WAIT_NEW) && cur_tick;
    ev[`SCSEL_EV_REFUSED] = req && !req_ok;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
    end else begin
      ist_r <= (ist_r & ~((wr && paddr == `SCSEL_OFF_ISTAT) ?
                pwdata[`SCSEL_EV_NUM-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= '0;
    end else if (wr && paddr == `SCSEL_OFF_IMASK) begin
      imask_r <= pwdata[`SCSEL_EV_NUM-1:0];
    end
  end

  assign irq = |(ist_r & imask_r);

  // --------------------------------------------------------------------------
  // Read data, captured in the setup cycle so it comes from a flip-flop.
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (rd_setup) begin
      if (paddr == `SCSEL_OFF_SRCSEL) begin
        prdata_r <= {31'h0, srcsel_r};
      end else if (paddr == `SCSEL_OFF_IOSC) begin
        prdata_r <= {24'h0, iosc_en_r, iosc_en_r, 4'h0, internal_clock_divider_field_r};
      end else if (paddr == `SCSEL_OFF_XOSC) begin
        prdata_r <= {24'h0, valid_r, xmode_r, 1'b0, xfreq_r}; // [RULE7] [RULE13]
      end else if (paddr == `SCSEL_OFF_ISTAT) begin
        prdata_r <= {29'h0, ist_r};
      end else if (paddr == `SCSEL_OFF_IMASK) begin
        prdata_r <= {29'h0, imask_r};
      end else begin
        prdata_r <= 32'h0;
      end
    end
  end

  assign prdata = prdata_r;

  // --------------------------------------------------------------------------
  // Assertions and covers.
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_INT_SOURCE: assert property (sysclk_is_ext && state_r == ST_RUN |-> srcsel_r) // [RULE1]
    else $error("External system clock kept without the select bit.");
  AST_EXT_NEEDS_SEL: assert property ($rose(sysclk_is_ext) |-> $past(srcsel_r)) // [RULE1]
    else $error("External source taken without the select bit.");
  AST_PERIPH: assert property (!sys_ext_r && pin_edge && xmode_r[2:1] == 2'b01
    |-> ext_periph_en) // [RULE2]
    else $error("Peripheral tick lost while internal source selected.");
  AST_SEL_READY: assert property (req && req_ok && req_ext |-> ext_ready) // [RULE3]
    else $error("Unsettled external source accepted.");
  AST_ONE_WRITE: assert property (wr_iosc && state_r == ST_RUN && pwdata[7] && pwdata[5]
    |=> iosc_en_r && !srcsel_r) // [RULE4]
    else $error("Single write did not enable and select internal.");
  AST_VALID_SET: assert property (mode_crystal(xmode_r) && !valid_r && pin_edge
    && settle_cnt_r == SETTLE_LAST && !wr_xosc |=> valid_r) // [RULE5]
    else $error("Crystal valid not set after settling.");
  AST_VALID_MODE: assert property (valid_r |-> xmode_r[2:1] == 2'b11) // [RULE7]
    else $error("Valid flag outside crystal mode.");
  AST_OFF: assert property (xmode_r[2:1] == 2'b00 |-> !ext_osc_on ##1 !ext_periph_en) // [RULE8]
    else $error("External oscillator active in off mode.");
  AST_CRYSTAL_FULL: assert property (xmode_r == 3'h6 && pin_edge |-> ext_periph_en) // [RULE11]
    else $error("Undivided crystal dropped an edge.");
  AST_BIT3: assert property (rd_setup && paddr == `SCSEL_OFF_XOSC |=> prdata[3] == 1'b0
    && prdata[31:8] == 24'h0) // [RULE13]
    else $error("Unused control bits read non-zero.");
  AST_DIV1: assert property (iosc_en_r && internal_clock_divider_field_r == 2'h3 && $past(internal_clock_divider_field_r) == 2'h3
    |-> int_tick) // [RULE17]
    else $error("Divide-by-one internal clock missed a cycle.");
  AST_DRAIN: assert property (state_r == ST_WAIT_NEW && $past(state_r) == ST_DRAIN
    |-> $past(drained)) // [RULE18]
    else $error("Source switched mid-period.");

  COV_TO_EXT: cover property (state_r == ST_WAIT_NEW && sys_ext_r ##[1:100] state_r == ST_RUN);
  COV_VALID: cover property ($rose(valid_r));
  COV_REFUSED: cover property (ev[`SCSEL_EV_REFUSED]);
  COV_IRQ: cover property ($rose(irq));

endmodule : scsel_ctrl

// *** scsel_osc_model.sv ***
// Behavioural external oscillator that drives the first oscillator pin.
`timescale 1ns/1ps

module scsel_osc_model #(
  parameter int HALF_NS = 170
) (
  input wire logic run,
  output logic pin
);
  // --------------------------------------------------------------------------
  // Square wave source.
  // --------------------------------------------------------------------------
  // The pin toggles only while the circuit is powered.
  // It stands at 0 otherwise, so a dead oscillator never looks like a held clock.
  initial pin = 1'b0;
  always begin
    #(HALF_NS);
    if (run) begin
      pin = ~pin;
    end else begin
      pin = 1'b0;
    end
  end
endmodule : scsel_osc_model

// *** scsel_pkg.sv ***
// Types shared by the clock select block.
package scsel_pkg;

  typedef logic [2:0] scsel_xmode_t;
  typedef logic [2:0] scsel_xfreq_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DRAIN = 2'b01,
    ST_WAIT_NEW = 2'b10
  } scsel_state_t;

endpackage : scsel_pkg

// *** scsel_regs.svh ***
// Register offsets, field positions, reset values and counts of the clock select block.
`ifndef SCSEL_REGS_SVH
`define SCSEL_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the APB window.
// ----------------------------------------------------------------------------
`define SCSEL_OFF_SRCSEL 8'h80
`define SCSEL_OFF_IOSC 8'h88
`define SCSEL_OFF_XOSC 8'h8c
`define SCSEL_OFF_ISTAT 8'h90
`define SCSEL_OFF_IMASK 8'h94

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define SCSEL_SRC_BIT 0
`define SCSEL_IOSC_EN_BIT 7
`define SCSEL_IOSC_RDY_BIT 6
`define SCSEL_IOSC_SEL_BIT 5
`define SCSEL_XOSC_VALID_BIT 7
`define SCSEL_EV_VALID 0
`define SCSEL_EV_SWITCHED 1
`define SCSEL_EV_REFUSED 2

// ----------------------------------------------------------------------------
// Reset values and counts.
// ----------------------------------------------------------------------------
`define SCSEL_XOSC_RESET 8'h00
`define SCSEL_IOSC_EN_RESET 1'b1
`define SCSEL_INTERNAL_CLOCK_DIVIDER_FIELD_RESET 2'h3
`define SCSEL_SETTLE_EDGES 1024
`define SCSEL_EV_NUM 3

`endif

// *** scsel_tick_div.sv ***
// Enable-pulse divider: passes every ratio-th source tick.
`timescale 1ns/1ps

module scsel_tick_div #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic src_tick,
  input wire logic [W-1:0] ratio,
  output logic tick
);

  logic [W-1:0] cnt_r;
  logic last;

  if (W < 2) begin : g_bad_width
    $error("scsel_tick_div needs W of at least 2");
  end

  // A ratio lowered mid-count fires at once, so no period ever grows past the old ratio.
  assign last = (cnt_r >= (ratio - {{(W-1){1'b0}}, 1'b1}));
  assign tick = en & src_tick & last;

  // Count source ticks and restart after each output tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!en) begin
      cnt_r <= '0;
    end else if (src_tick) begin
      cnt_r <= last ? '0 : cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule : scsel_tick_div

// *** tb_scsel_ctrl.sv ***
// Self-checking testbench of the clock select and external oscillator block.
`timescale 1ns/1ps
`include "scsel_regs.svh"

module tb_scsel_ctrl;
  import scsel_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, osc_pin, sysclk_en, ext_periph_en, sysclk_is_ext;
  logic ext_osc_on, int_osc_on, irq;
  scsel_xmode_t ext_osc_mode;
  scsel_xfreq_t ext_freq_range;
  int failures = 0;
  int check_count = 0;
  int pin_edges = 0;
  int pe, xe, se;
  logic [31:0] rd;
  logic err;

  // --------------------------------------------------------------------------
  // Clock, partner and design.
  // --------------------------------------------------------------------------
  // Short settle count keeps the crystal start-up within a few pin periods.
  always #20 pclk = ~pclk;
  always @(posedge osc_pin) pin_edges++;
  scsel_osc_model #(.HALF_NS(170)) osc (.run(ext_osc_on), .pin(osc_pin));
  scsel_ctrl #(.SETTLE_EDGES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_pin_one(osc_pin), .sysclk_en(sysclk_en),
    .ext_periph_en(ext_periph_en), .sysclk_is_ext(sysclk_is_ext), .ext_osc_on(ext_osc_on),
    .ext_osc_mode(ext_osc_mode), .ext_freq_range(ext_freq_range),
    .int_osc_on(int_osc_on), .irq(irq));

  // --------------------------------------------------------------------------
  // Reporting and bus tasks.
  // --------------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Counts cross clock domains, so a one-tick slack covers the sync delay.
  task automatic near(input string nm, input int exp, input int got);
    check_count++;
    if (got < exp - 1 || got > exp + 1) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : near

  // One APB transfer: setup, then access held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      chk("pready", 32'h1, 32'h0);
      end_sim();
    end
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rchk

  task automatic count_win(input int ncyc);
    int p0;
    p0 = pin_edges;
    xe = 0;
    se = 0;
    repeat (ncyc) begin
      @(posedge pclk);
      if (ext_periph_en === 1'b1) xe++;
      if (sysclk_en === 1'b1) se++;
    end
    pe = pin_edges - p0;
  endtask : count_win

  // Waits a bounded time for the system clock source to settle on v.
  task automatic wait_src(input logic v);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge pclk);
      if (sysclk_is_ext === v) break;
    end
    chk("sysclk_is_ext", {31'h0, v}, {31'h0, sysclk_is_ext});
    if (n == 300) end_sim();
  endtask : wait_src

  // --------------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("xosc reset", `SCSEL_OFF_XOSC, 32'h00);
    rchk("iosc reset", `SCSEL_OFF_IOSC, 32'hc3);
    rchk("srcsel reset", `SCSEL_OFF_SRCSEL, 32'h0);
    // Bit 7 is read-only and bit 3 always reads zero.
    apb(1'b1, `SCSEL_OFF_XOSC, 32'hff);
    rchk("xosc ro bits", `SCSEL_OFF_XOSC, 32'h77);
    // Every mode with RC band code 100, internal clock still selected.
    for (int m = 0; m < 8; m++) begin
      v = {1'b0, m[2:0], 4'h4};
      apb(1'b1, `SCSEL_OFF_XOSC, {24'h0, v});
      if (m == 6) rchk("valid early", `SCSEL_OFF_XOSC, {24'h0, v});
      count_win(200);
      chk("ext_osc_on", m[2:1] != 2'b00, ext_osc_on);
      chk("mode out", m, ext_osc_mode);
      chk("freq out", 32'h4, ext_freq_range);
      if (m < 2) chk("off ticks", 32'h0, xe);
      else if (m == 4 || m == 5 || m == 7) near("half ticks", pe / 2, xe);
      else near("full ticks", pe, xe);
      chk("int source", 32'h0, sysclk_is_ext);
      v[7] = (m >= 6);
      rchk("valid flag", `SCSEL_OFF_XOSC, {24'h0, v});
    end
    rchk("valid rose", `SCSEL_OFF_ISTAT, 32'h1);
    apb(1'b1, `SCSEL_OFF_IMASK, 32'h1);
    // The mask lands on the access edge, so the level is looked at half a cycle later.
    @(negedge pclk);
    chk("irq on", 32'h1, irq);
    apb(1'b1, `SCSEL_OFF_ISTAT, 32'h1);
    @(negedge pclk);
    chk("irq off", 32'h0, irq);
    // Crystal without division, code for the top frequency band.
    apb(1'b1, `SCSEL_OFF_XOSC, 32'h67);
    apb(1'b1, `SCSEL_OFF_SRCSEL, 32'h1);
    wait_src(1'b1);
    count_win(200);
    near("ext sysclk", pe, se);
    rchk("switch done", `SCSEL_OFF_ISTAT, 32'h2);
    // One write enables the internal oscillator and selects it.
    apb(1'b1, `SCSEL_OFF_IOSC, 32'ha3);
    wait_src(1'b0);
    chk("int on", 32'h1, int_osc_on);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `SCSEL_OFF_IOSC, 32'ha0 | c);
      count_win(64);
      near("int divide", 64 >> (3 - c), se);
    end
    // Selecting a dead oscillator is refused and raises an event.
    apb(1'b1, `SCSEL_OFF_ISTAT, 32'hff);
    apb(1'b1, `SCSEL_OFF_XOSC, 32'h00);
    apb(1'b1, `SCSEL_OFF_IMASK, 32'h4);
    apb(1'b1, `SCSEL_OFF_SRCSEL, 32'h1);
    repeat (40) @(posedge pclk);
    chk("refused src", 32'h0, sysclk_is_ext);
    rchk("refused stat", `SCSEL_OFF_ISTAT, 32'h4);
    chk("irq refused", 32'h1, irq);
    rchk("mask", `SCSEL_OFF_IMASK, 32'h4);
    apb(1'b1, `SCSEL_OFF_ISTAT, 32'h4);
    @(negedge pclk);
    chk("irq cleared", 32'h0, irq);
    // Unmapped address answers with an error and zero data.
    apb(1'b0, 8'h84, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    end_sim();
  end
endmodule : tb_scsel_ctrl
